/* pkg/t1_li_pkg.sv */
package t1_li_pkg;

  // ------------------------------------------------------------
  // Register map and field layout
  // ------------------------------------------------------------
  localparam logic [7:0] LINE_INTERFACE_CONTROL_OFFSET = 8'h00;
  localparam logic [7:0] RECEIVE_INFO_2_OFFSET = 8'h04;
  localparam logic [7:0] MASK_OFFSET = 8'h08;
  localparam logic [7:0] STAT_OFFSET = 8'h0C;
  localparam int BO_LSB = 5;
  localparam int EGL_BIT = 4;
  localparam int JAS_BIT = 3;
  localparam int JA_DEPTH_SELECT_BIT = 2;
  localparam int DJA_BIT = 1;
  localparam int TPD_BIT = 0;
  localparam logic [7:0] LINE_INTERFACE_CONTROL_RESET = 8'h00;
  localparam int JA_LIMIT_TRIP_BIT = 2;
  localparam int CLOSS_BIT = 0;
  localparam logic [7:0] RECEIVE_INFO_2_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;

  // ------------------------------------------------------------
  // Jitter attenuator sizing and trip levels
  // ------------------------------------------------------------
  localparam int JA_DEEP = 128;
  localparam int JA_SHALLOW = 32;
  localparam logic [7:0] DEEP_HI = 8'h7C;
  localparam logic [7:0] DEEP_LO = 8'h04;
  localparam logic [7:0] SHALLOW_HI = 8'h1E;
  localparam logic [7:0] SHALLOW_LO = 8'h02;
  localparam logic [3:0] DIV_NORMAL = 4'h8;
  localparam logic [3:0] DIV_FAST = 4'h7;
  localparam logic [3:0] DIV_SLOW = 4'h9;

  // ------------------------------------------------------------
  // Recovery timing, counted in crystal edges
  // ------------------------------------------------------------
  localparam int PLL_MULT = 4;
  localparam int OVERSAMPLE = 32;
  localparam logic [3:0] EDGES_PER_BIT = 4'(OVERSAMPLE / PLL_MULT);
  localparam logic [7:0] CL_BITS = 8'hC0;
  localparam logic [6:0] ACLK_WINDOW = 7'h40;
  localparam logic [3:0] ACLK_MIN = 4'h4;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    BO_DSX_0_133 = 3'b000,
    BO_DSX_133_266 = 3'b001,
    BO_DSX_266_399 = 3'b010,
    BO_DSX_399_533 = 3'b011,
    BO_DSX_533_655 = 3'b100,
    BO_CSU_7P5 = 3'b101,
    BO_CSU_15 = 3'b110,
    BO_CSU_22P5 = 3'b111
  } build_out_t;

  typedef enum logic [1:0] {
    SRC_RECOVERED = 2'b00,
    SRC_JA = 2'b01,
    SRC_ALT = 2'b10
  } rclk_src_t;

endpackage : t1_li_pkg

/* hdl/ja_buffer.sv */
`timescale 1ns/1ps
module ja_buffer
  import t1_li_pkg::*;
#(
  parameter int MAX_DEPTH = JA_DEEP
)(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Control
  input wire logic shallow,
  input wire logic flush,
  // Write side
  input wire logic wr_en,
  input wire logic wr_bit,
  // Read side
  input wire logic rd_en,
  output logic rd_bit,
  output logic [7:0] fill
);

  logic mem [MAX_DEPTH];
  logic [6:0] wr_ptr;
  logic [6:0] rd_ptr;
  logic [6:0] last;
  logic [7:0] depth;
  logic full;
  logic empty;

  // The active depth is either the deep or the shallow size.
  assign depth = shallow ? 8'(JA_SHALLOW) : 8'(JA_DEEP);
  assign last = 7'(depth - 8'h01);
  assign full = fill >= depth;
  assign empty = fill == 8'h00;

  // Bit storage.
  always_ff @(posedge ref_clk)
  begin
    if (wr_en && !full)
      mem[wr_ptr] <= wr_bit;
  end

  // Pointers and fill; a flush re-centres the buffer.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr <= 7'h40;
      rd_ptr <= 7'h00;
      fill <= 8'h40;
      rd_bit <= 1'b0;
    end
    else if (flush)
    begin
      wr_ptr <= 7'(depth >> 1);
      rd_ptr <= 7'h00;
      fill <= depth >> 1;
    end
    else
    begin
      if (wr_en && !full)
        wr_ptr <= (wr_ptr >= last) ? 7'h00 : 7'(wr_ptr + 7'h01);
      if (rd_en && !empty)
      begin
        rd_bit <= mem[rd_ptr];
        rd_ptr <= (rd_ptr >= last) ? 7'h00 : 7'(rd_ptr + 7'h01);
      end
      if ((wr_en && !full) && !(rd_en && !empty))
        fill <= 8'(fill + 8'h01);
      else if (!(wr_en && !full) && (rd_en && !empty))
        fill <= 8'(fill - 8'h01);
    end
  end

endmodule : ja_buffer

/* hdl/t1_line_interface_jitter_ctrl.sv */
`timescale 1ns/1ps
module t1_line_interface_jitter_ctrl
  import t1_li_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Line and clock pins
  input wire logic crystal_pin_a,
  input wire logic alternate_clock_in,
  input wire logic transmit_clock_in,
  input wire logic tx_data_in,
  input wire logic rx_line_pos,
  input wire logic rx_line_neg,
  output logic tx_line_pos,
  output logic tx_line_neg,
  output logic tx_line_oe,
  // Receive outputs
  output logic rx_clk_out,
  output logic rx_data_out,
  // Analog controls
  output logic [2:0] build_out_sel,
  output logic csu_shape,
  output logic eq_gain_limit,
  output logic xtal_load_add,
  // Interrupt
  output logic irq
);

  // ------------------------------------------------------------
  // Reset and pin synchronisers
  // ------------------------------------------------------------
  logic [1:0] rst_pipe;
  logic rst_sync_n;
  logic [5:0] pin_s1;
  logic [5:0] pin_s2;
  logic [5:0] pin_d;
  logic [5:0] pin_rise;
  logic [5:0] pin_fall;

  // Reset release passes two flip-flops.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      rst_pipe <= 2'b00;
    else
      rst_pipe <= {rst_pipe[0], 1'b1};
  end
  assign rst_sync_n = rst_pipe[1];

  // All pins pass two flip-flops; a third stage gives edges.
  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      pin_s1 <= 6'h00;
      pin_s2 <= 6'h00;
      pin_d <= 6'h00;
    end
    else
    begin
      pin_s1 <= {rx_line_neg, rx_line_pos, tx_data_in, transmit_clock_in,
                 alternate_clock_in, crystal_pin_a};
      pin_s2 <= pin_s1;
      pin_d <= pin_s2;
    end
  end
  assign pin_rise = pin_s2 & ~pin_d;
  assign pin_fall = ~pin_s2 & pin_d;

  logic xtal_edge;
  logic alt_rise;
  logic tx_rise;
  logic tx_bit;
  logic line_pulse;
  assign xtal_edge = pin_rise[0] | pin_fall[0];
  assign alt_rise = pin_rise[1];
  assign tx_rise = pin_rise[2];
  assign tx_bit = pin_s2[3];
  assign line_pulse = pin_rise[4] | pin_rise[5];

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [7:0] line_interface_control;
  logic [7:0] receive_info_2;
  logic [7:0] mask;
  logic [7:0] rd_snap;
  logic [7:0] rd_value;
  logic setup_phase;
  logic access_done;
  logic mapped;
  logic [7:0] set_events;
  logic carrier_loss;
  logic alt_present;
  logic [7:0] fill;

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == LINE_INTERFACE_CONTROL_OFFSET) || (a == RECEIVE_INFO_2_OFFSET) ||
                (a == MASK_OFFSET) || (a == STAT_OFFSET);
  endfunction : is_mapped

  assign setup_phase = psel && !penable;
  assign access_done = psel && penable;
  assign mapped = is_mapped(paddr);
  assign pready = access_done;
  assign pslverr = access_done && !mapped;

  // Control and mask registers written by software.
  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      line_interface_control <= LINE_INTERFACE_CONTROL_RESET;
      mask <= MASK_RESET;
    end
    else if (access_done && pwrite)
    begin
      if (paddr == LINE_INTERFACE_CONTROL_OFFSET)
        line_interface_control <= pwdata[7:0];
      if (paddr == MASK_OFFSET)
        mask <= pwdata[7:0];
    end
  end

  // Value of the addressed register, as a read would return it.
  always_comb
  begin
    case (paddr)
      LINE_INTERFACE_CONTROL_OFFSET: rd_value = line_interface_control;
      RECEIVE_INFO_2_OFFSET: rd_value = receive_info_2;
      MASK_OFFSET: rd_value = mask;
      STAT_OFFSET: rd_value = {6'h00, alt_present, carrier_loss};
      default: rd_value = 8'h00;
    endcase
  end

  // Read data is captured in the setup cycle and held for access.
  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      rd_snap <= 8'h00;
    else if (setup_phase && !pwrite)
      rd_snap <= rd_value;
  end

  // Bits 15:8 of a status read carry the buffer fill for software.
  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      prdata <= 32'h0000_0000;
    else if (setup_phase && !pwrite)
      prdata <= {16'h0000, (paddr == STAT_OFFSET) ? fill : 8'h00, rd_value};
    else if (access_done)
      prdata <= 32'h0000_0000;
  end

  // Sticky events; a read clears the bits it returned, new events win.
  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      receive_info_2 <= RECEIVE_INFO_2_RESET;
    else if (access_done && !pwrite && paddr == RECEIVE_INFO_2_OFFSET)
      receive_info_2 <= (receive_info_2 & ~rd_snap) | set_events;
    else
      receive_info_2 <= receive_info_2 | set_events;
  end

  assign irq = |(receive_info_2 & mask);

  // ------------------------------------------------------------
  // Control decode
  // ------------------------------------------------------------
  logic ja_off;
  logic ja_tx;
  logic ja_shallow;

  assign ja_off = line_interface_control[DJA_BIT];
  assign ja_tx = line_interface_control[JAS_BIT];
  assign ja_shallow = line_interface_control[JA_DEPTH_SELECT_BIT];

  // Build-out code and gain limit drive the analog front end.
  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      build_out_sel <= 3'b000;
      csu_shape <= 1'b0;
      eq_gain_limit <= 1'b0;
    end
    else
    begin
      build_out_sel <= line_interface_control[BO_LSB +: 3];
      csu_shape <= build_out_t'(line_interface_control[BO_LSB +: 3]) > BO_DSX_533_655;
      eq_gain_limit <= line_interface_control[EGL_BIT];
    end
  end

  // ------------------------------------------------------------
  // Clock recovery and carrier loss
  // ------------------------------------------------------------
  logic [3:0] bit_phase;
  logic rec_clk;
  logic rec_bit;
  logic pulse_seen;
  logic rec_tick;
  logic [7:0] quiet_bits;

  // One bit is OVERSAMPLE / PLL_MULT, eight, crystal edges.
  assign rec_tick = xtal_edge && (bit_phase == EDGES_PER_BIT - 4'h1);
  assign rec_clk = bit_phase < (EDGES_PER_BIT >> 1);

  // A line pulse re-aligns the bit phase, which may cut a low short or stretch a high.
  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      bit_phase <= 4'h0;
      pulse_seen <= 1'b0;
      rec_bit <= 1'b0;
    end
    else
    begin
      if (line_pulse)
        bit_phase <= 4'h0;
      else if (rec_tick)
        bit_phase <= 4'h0;
      else if (xtal_edge)
        bit_phase <= 4'(bit_phase + 4'h1);
      if (rec_tick)
      begin
        rec_bit <= pulse_seen | line_pulse;
        pulse_seen <= 1'b0;
      end
      else if (line_pulse)
        pulse_seen <= 1'b1;
    end
  end

  // Carrier is lost after a run of bit times without any pulse.
  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      quiet_bits <= 8'h00;
      carrier_loss <= 1'b1;
    end
    else if (line_pulse)
    begin
      quiet_bits <= 8'h00;
      carrier_loss <= 1'b0;
    end
    else if (xtal_edge && bit_phase == EDGES_PER_BIT - 4'h1)
    begin
      if (quiet_bits >= CL_BITS - 8'h01)
        carrier_loss <= 1'b1;
      else
        quiet_bits <= 8'(quiet_bits + 8'h01);
    end
  end

  // ------------------------------------------------------------
  // Alternate clock detection
  // ------------------------------------------------------------
  logic [6:0] win_count;
  logic [3:0] alt_edges;

  // Rising edges are counted over a fixed window of crystal edges.
  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      win_count <= 7'h00;
      alt_edges <= 4'h0;
      alt_present <= 1'b0;
    end
    else
    begin
      if (xtal_edge && win_count == ACLK_WINDOW - 7'h01)
      begin
        win_count <= 7'h00;
        alt_present <= alt_edges >= ACLK_MIN;
        alt_edges <= 4'h0;
      end
      else
      begin
        if (xtal_edge)
          win_count <= 7'(win_count + 7'h01);
        if (alt_rise && alt_edges != 4'hF)
          alt_edges <= 4'(alt_edges + 4'h1);
      end
    end
  end

  // ------------------------------------------------------------
  // Attenuator clock divider and buffer
  // ------------------------------------------------------------
  logic [3:0] div_count;
  logic [3:0] div_ratio;
  logic ja_clk;
  logic ja_rd;
  logic ja_wr;
  logic ja_wr_bit;
  logic ja_out_bit;
  logic ja_flush;
  logic centred_only;
  logic [7:0] hi_trip;
  logic [7:0] lo_trip;
  logic [7:0] centre;

  assign hi_trip = ja_shallow ? SHALLOW_HI : DEEP_HI;
  assign lo_trip = ja_shallow ? SHALLOW_LO : DEEP_LO;
  assign centre = ja_shallow ? 8'(JA_SHALLOW / 2) : 8'(JA_DEEP / 2);
  // Receive path, carrier lost, no alternate: plain crystal by four.
  assign centred_only = carrier_loss && !alt_present && !ja_tx;
  assign ja_rd = xtal_edge && (div_count == div_ratio - 4'h1);
  assign ja_clk = div_count < (DIV_NORMAL >> 1);

  // Ratio picks 3.5 or 4.5 near the buffer limits, else 4.
  always_comb
  begin
    if (centred_only || ja_off)
      div_ratio = DIV_NORMAL;
    else if (fill >= hi_trip)
      div_ratio = DIV_FAST;
    else if (fill <= lo_trip)
      div_ratio = DIV_SLOW;
    else
      div_ratio = DIV_NORMAL;
  end

  // Divider counts crystal edges; a period ends on the ratio.
  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      div_count <= 4'h0;
    else if (ja_rd)
      div_count <= 4'h0;
    else if (xtal_edge)
      div_count <= 4'(div_count + 4'h1);
  end

  // Crystal pull keeps the long-term read rate on the line rate.
  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      xtal_load_add <= 1'b0;
    else
      xtal_load_add <= !ja_off && (fill < centre);
  end

  // Events for the sticky status register.
  logic loss_d;
  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      loss_d <= 1'b1;
    else
      loss_d <= carrier_loss;
  end
  always_comb
  begin
    set_events = 8'h00;
    set_events[JA_LIMIT_TRIP_BIT] = ja_rd && (div_ratio != DIV_NORMAL);
    set_events[CLOSS_BIT] = carrier_loss && !loss_d;
  end

  // Write side follows the path the attenuator sits in.
  always_comb
  begin
    if (ja_tx)
    begin
      ja_wr = tx_rise;
      ja_wr_bit = tx_bit;
    end
    else if (carrier_loss)
    begin
      ja_wr = alt_present && alt_rise;
      ja_wr_bit = 1'b1;
    end
    else
    begin
      ja_wr = rec_tick;
      ja_wr_bit = rec_bit;
    end
  end

  // Re-centre on disable, depth change or path change.
  logic [1:0] cfg_d;
  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      cfg_d <= 2'b00;
    else
      cfg_d <= {ja_shallow, ja_tx};
  end
  assign ja_flush = ja_off || (cfg_d != {ja_shallow, ja_tx});

  ja_buffer #(
    .MAX_DEPTH(JA_DEEP)
  ) u_ja_buffer (
    .ref_clk(ref_clk),
    .rst_n(rst_sync_n),
    .shallow(ja_shallow),
    .flush(ja_flush),
    .wr_en(ja_wr && !ja_off),
    .wr_bit(ja_wr_bit),
    .rd_en(ja_rd && !ja_off && !centred_only),
    .rd_bit(ja_out_bit),
    .fill(fill)
  );

  // ------------------------------------------------------------
  // Receive clock source
  // ------------------------------------------------------------
  rclk_src_t rx_src;

  // Source table for normal operation and carrier loss.
  always_comb
  begin
    if (!carrier_loss)
      rx_src = (!ja_off && !ja_tx) ? SRC_JA : SRC_RECOVERED;
    else if (alt_present)
      rx_src = (!ja_off && !ja_tx) ? SRC_JA : SRC_ALT;
    else
      rx_src = ja_off ? SRC_JA : SRC_JA;
  end

  // Receive clock and data leave from flip-flops.
  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      rx_clk_out <= 1'b0;
      rx_data_out <= 1'b0;
    end
    else
    begin
      case (rx_src)
        SRC_JA:
        begin
          rx_clk_out <= ja_clk;
          rx_data_out <= centred_only ? 1'b1 : ja_out_bit;
        end
        SRC_ALT:
        begin
          rx_clk_out <= pin_s2[1];
          rx_data_out <= 1'b1;
        end
        SRC_RECOVERED:
        begin
          rx_clk_out <= rec_clk;
          rx_data_out <= rec_bit;
        end
        default:
        begin
          rx_clk_out <= 1'b0;
          rx_data_out <= 1'b0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Transmit driver
  // ------------------------------------------------------------
  logic tx_use_ja;
  logic tx_clk_sel;
  logic tx_strobe;
  logic tx_mark;
  logic tx_polarity;

  assign tx_use_ja = ja_tx && !ja_off;
  assign tx_clk_sel = tx_use_ja ? ja_clk : pin_s2[2];
  assign tx_strobe = tx_use_ja ? ja_rd : tx_rise;

  // Marks alternate polarity and drive for the high clock phase.
  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      tx_mark <= 1'b0;
      tx_polarity <= 1'b0;
    end
    else if (tx_strobe)
    begin
      tx_mark <= tx_use_ja ? ja_out_bit : tx_bit;
      if (tx_use_ja ? ja_out_bit : tx_bit)
        tx_polarity <= !tx_polarity;
    end
  end

  // Power-down floats both line outputs and silences them.
  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      tx_line_pos <= 1'b0;
      tx_line_neg <= 1'b0;
      tx_line_oe <= 1'b0;
    end
    else
    begin
      tx_line_oe <= !line_interface_control[TPD_BIT];
      tx_line_pos <= !line_interface_control[TPD_BIT] && tx_mark && tx_polarity && tx_clk_sel;
      tx_line_neg <= !line_interface_control[TPD_BIT] && tx_mark && !tx_polarity && tx_clk_sel;
    end
  end

endmodule : t1_line_interface_jitter_ctrl

/* testbench/t1_li_assertions.sv */
`timescale 1ns/1ps
module t1_li_assertions
  import t1_li_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Line and control outputs
  input wire logic tx_line_oe,
  input wire logic [2:0] build_out_sel,
  input wire logic csu_shape,
  input wire logic eq_gain_limit
);
  // --------
  // Helpers
  // --------
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  logic mapped;

  // Marks the four register addresses that the block decodes.
  assign mapped = paddr inside {LINE_INTERFACE_CONTROL_OFFSET, RECEIVE_INFO_2_OFFSET, MASK_OFFSET,
    STAT_OFFSET};

  sequence access_s;
    psel && penable;
  endsequence

  sequence ctrl_wr_s;
    psel && penable && pwrite && paddr == LINE_INTERFACE_CONTROL_OFFSET;
  endsequence

  property bo_p;
    logic [2:0] b;
    (ctrl_wr_s, b = pwdata[7:5]) |-> ##2 build_out_sel == b;
  endproperty

  property csu_p;
    logic [2:0] b;
    (ctrl_wr_s, b = pwdata[7:5]) |-> ##2 csu_shape == (b >= 3'h5);
  endproperty

  property gain_p;
    logic g;
    (ctrl_wr_s, g = pwdata[4]) |-> ##2 eq_gain_limit == g;
  endproperty

  // --------
  // Checks
  // --------
  a_zero_wait: assert property (access_s |-> pready)
    else $error("access phase without ready");
  a_idle_quiet: assert property (!(psel && penable) |-> !pready && !pslverr)
    else $error("ready or error outside access phase");
  a_unmapped_err: assert property (access_s ##0 !mapped |-> pslverr)
    else $error("unmapped access without error");
  a_mapped_ok: assert property (access_s ##0 mapped |-> !pslverr)
    else $error("mapped access flagged as error");
  a_unmapped_rdz: assert property (access_s ##0 !pwrite && !mapped
    |-> prdata == 32'h0)
    else $error("unmapped read returned data");
  a_idle_rdz: assert property (!psel && !$past(psel) |-> prdata == 32'h0)
    else $error("read data not cleared when idle");
  a_build_out: assert property (bo_p)
    else $error("build-out output does not follow control");
  a_csu_shape: assert property (csu_p)
    else $error("shape flag wrong for build-out code");
  a_gain_copy: assert property (gain_p)
    else $error("gain limit output does not follow control");
  a_pd_float: assert property (ctrl_wr_s ##0 pwdata[0]
    |-> ##[1:4] !tx_line_oe)
    else $error("line outputs still driven in power-down");
  c_ctrl_wr: cover property (ctrl_wr_s);
endmodule : t1_li_assertions

bind t1_line_interface_jitter_ctrl t1_li_assertions chk_i (.ref_clk,
  .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .tx_line_oe, .build_out_sel, .csu_shape, .eq_gain_limit);

/* testbench/t1_line_model.sv */
`timescale 1ns/1ps
module t1_line_model
(
  // Pins toward the block
  output logic crystal_pin_a,
  output logic alternate_clock_in,
  output logic transmit_clock_in,
  output logic rx_line_pos,
  output logic rx_line_neg,
  // Scenario controls
  input wire logic line_on,
  input wire logic alt_on,
  input wire logic [15:0] bit_ns,
  input wire logic [15:0] alt_ns
);
  logic mark_pos;

  // Crystal at 6.176 MHz and transmit clock at a quarter of it.
  initial
  begin
    crystal_pin_a = 1'b0;
    transmit_clock_in = 1'b0;
    mark_pos = 1'b0;
    fork
      forever #80.959 crystal_pin_a = ~crystal_pin_a;
      forever #323.834 transmit_clock_in = ~transmit_clock_in;
    join
  end

  // Alternate clock, held at ground when unused.
  always
  begin
    alternate_clock_in = alt_on;
    #(alt_ns / 2);
    alternate_clock_in = 1'b0;
    #(alt_ns / 2);
  end

  // All-ones AMI line; with no carrier both pins sit at zero.
  always
  begin
    if (line_on === 1'b1)
    begin
      mark_pos = ~mark_pos;
      rx_line_pos = mark_pos;
      rx_line_neg = ~mark_pos;
    end
    #(bit_ns / 2);
    rx_line_pos = 1'b0;
    rx_line_neg = 1'b0;
    #(bit_ns / 2);
  end
endmodule : t1_line_model

/* testbench/t1_line_interface_jitter_ctrl_tb.sv */
`timescale 1ns/1ps
module t1_line_interface_jitter_ctrl_tb
  import t1_li_pkg::*;
;
  logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, e, trip;
  logic [7:0] paddr, v;
  logic [31:0] pwdata, prdata, q;
  logic crystal_pin_a, alternate_clock_in, transmit_clock_in, tx_data_in;
  logic rx_line_pos, rx_line_neg, tx_line_pos, tx_line_neg, tx_line_oe;
  logic rx_clk_out, rx_data_out, csu_shape, eq_gain_limit, xtal_load_add;
  logic irq, line_on, alt_on;
  logic [2:0] build_out_sel;
  logic [15:0] bit_ns, alt_ns;
  int errors, tests_run, cyc, n, i;

  t1_line_interface_jitter_ctrl uut (.ref_clk, .rst_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .crystal_pin_a,
    .alternate_clock_in, .transmit_clock_in, .tx_data_in, .rx_line_pos,
    .rx_line_neg, .tx_line_pos, .tx_line_neg, .tx_line_oe, .rx_clk_out,
    .rx_data_out, .build_out_sel, .csu_shape, .eq_gain_limit,
    .xtal_load_add, .irq);
  t1_line_model line_i (.crystal_pin_a, .alternate_clock_in,
    .transmit_clock_in, .rx_line_pos, .rx_line_neg, .line_on, .alt_on,
    .bit_ns, .alt_ns);

  // --------
  // Tasks
  // --------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic er);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] x);
    apb(1'b0, a, 32'h0, q, e);
    chk(q & m, x);
  endtask : rd

  task automatic rises(input int len, input int per_ns);
    logic p;
    int c, x;
    c = 0;
    x = len * 50 / per_ns;
    p = rx_clk_out;
    repeat (len)
    begin
      @(posedge ref_clk);
      c += (rx_clk_out === 1'b1 && p !== 1'b1);
      p = rx_clk_out;
    end
    chk({31'h0, c >= x - 4 && c <= x + 4}, 32'h1);
  endtask : rises

  task automatic finish_test;
    $display("counts: errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test

  // --------
  // Clock, data and watchdog
  // --------
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // Random transmit data and a cycle ceiling against hangs.
  always @(posedge ref_clk)
  begin
    tx_data_in <= 1'($urandom);
    cyc++;
    if (cyc == 60000)
    begin
      errors++;
      finish_test;
    end
  end

  // --------
  // Scenarios
  // --------
  initial
  begin
    {rst_n, psel, penable, pwrite, line_on, alt_on, tx_data_in} = '0;
    {paddr, pwdata} = '0;
    bit_ns = 16'd648;
    alt_ns = 16'd800;
    void'($urandom(32'h969dfc93));
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(LINE_INTERFACE_CONTROL_OFFSET, 32'hFF, 32'h0);
    rd(RECEIVE_INFO_2_OFFSET, 32'hFF, 32'h0);
    rd(MASK_OFFSET, 32'hFF, 32'h0);
    rd(STAT_OFFSET, 32'h3, 32'h1);
    apb(1'b1, 8'h10, 32'hFF, q, e);
    chk(e, 32'h1);
    apb(1'b0, 8'h10, 32'h0, q, e);
    chk({q[30:0], e}, 32'h1);
    $display("reset and map test done");
    for (i = 0; i < 8; i++)
    begin
      v = {i[2:0], 5'($urandom) | 5'h02};
      apb(1'b1, LINE_INTERFACE_CONTROL_OFFSET, {24'h0, v}, q, e);
      rd(LINE_INTERFACE_CONTROL_OFFSET, 32'hFF, {24'h0, v});
      repeat (2) @(posedge ref_clk);
      chk(build_out_sel, v[7:5]);
      chk(csu_shape, v[7:5] >= 3'h5);
      chk(eq_gain_limit, v[4]);
      n = 0;
      repeat (300) @(posedge ref_clk) n += (tx_line_oe === 1'b1);
      chk(n > 0, !v[0]);
      if (v[0])
        chk(tx_line_pos | tx_line_neg, 32'h0);
    end
    $display("control field test done");
    apb(1'b1, LINE_INTERFACE_CONTROL_OFFSET, 32'h02, q, e);
    apb(1'b1, MASK_OFFSET, 32'h05, q, e);
    line_on = 1'b1;
    repeat (2000) @(posedge ref_clk);
    rd(STAT_OFFSET, 32'h1, 32'h0);
    apb(1'b0, RECEIVE_INFO_2_OFFSET, 32'h0, q, e);
    line_on = 1'b0;
    repeat (3500) @(posedge ref_clk);
    chk(irq, 1'b1);
    apb(1'b1, MASK_OFFSET, 32'h0, q, e);
    chk(irq, 1'b0);
    apb(1'b1, MASK_OFFSET, 32'h05, q, e);
    chk(irq, 1'b1);
    rd(RECEIVE_INFO_2_OFFSET, 32'h1, 32'h1);
    chk(irq, 1'b0);
    rises(1000, 648);
    alt_on = 1'b1;
    apb(1'b1, LINE_INTERFACE_CONTROL_OFFSET, 32'h08, q, e);
    repeat (200) @(posedge ref_clk);
    rd(STAT_OFFSET, 32'h2, 32'h2);
    rises(1000, 800);
    alt_on = 1'b0;
    repeat (200) @(posedge ref_clk);
    rd(STAT_OFFSET, 32'h2, 32'h0);
    rises(1000, 648);
    $display("carrier loss test done");
    line_on = 1'b1;
    repeat (500) @(posedge ref_clk);
    apb(1'b1, LINE_INTERFACE_CONTROL_OFFSET, 32'h00, q, e);
    rd(STAT_OFFSET, 32'h0, 32'h0);
    chk(q[15:8] >= 8'd60 && q[15:8] <= 8'd68, 32'h1);
    apb(1'b1, LINE_INTERFACE_CONTROL_OFFSET, 32'h04, q, e);
    rd(STAT_OFFSET, 32'h0, 32'h0);
    chk(q[15:8] >= 8'd12 && q[15:8] <= 8'd20, 32'h1);
    bit_ns = 16'd620;
    trip = 1'b0;
    repeat (40)
    begin
      repeat (200) @(posedge ref_clk);
      apb(1'b0, RECEIVE_INFO_2_OFFSET, 32'h0, q, e);
      trip |= q[JA_LIMIT_TRIP_BIT];
      rd(STAT_OFFSET, 32'h0, 32'h0);
      chk(q[15:8] <= 8'd32, 32'h1);
    end
    chk(trip, 1'b1);
    $display("jitter attenuator test done");
    finish_test;
  end
endmodule : t1_line_interface_jitter_ctrl_tb
